// File: hce_timing_core.sv
// horizontal clock edge placement core with Avalon-MM register slave
// Behaviour
// - in modes 1 to 3 the first clock rises at the low six-bit field and falls at the field above, reset 0x20.
// - in three-phase mode the first edge register places phase 3 on the seventh and eighth outputs.
// - in mode 2 the second clock takes its edges from the second edge register.
// - in mode 3 the second edge register drives the fifth clock instead of the second.
// - in three-phase mode the second edge register places phase 2 on the fifth and sixth outputs.
// - the last-stage clock takes its edges from its own register, reset 0 and 0x20.
// - in three-phase mode phase 1 on the first and second outputs comes from its own register.
// - the reset gate clock takes its edges from its register, whose fall field resets to 0x10.
// - a set retime bit delays a group's blanking gate by one retime stage.
// - a nonzero wide-clock setting widens the clocks during blanking, zero disables it.
// - the last-stage clock is blanked only when its blanking enable bit is set.
// - a set extra-retime bit adds a further retime stage to that group's blanking gate.
// - the configuration selector's low five bits take 0x01, 0x02, 0x04 or 0x10, any other value is invalid; bit 5 is ignored.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "hce_map.svh"
module hce_timing_core
  import hce_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm register slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // blanking gate from the horizontal timing
  input  wire logic        horizontal_blanking_gate,
  // clock driver outputs, bit 0 is the first clock
  output logic      [7:0]  h_clk,
  output logic             last_stage_horiz_clock,
  output logic             reset_gate_clock
);

  localparam int NGEN = 5;
  localparam int G_FIRST = 0;
  localparam int G_SECOND = 1;
  localparam int G_LAST = 2;
  localparam int G_P1 = 3;
  localparam int G_RG = 4;

  // registers
  logic [`HCE_EDGE_W-1:0] edge_q [NGEN];
  logic [`HCE_BLK_W-1:0]  blank_ctl_q;
  logic [`HCE_SEL_W-1:0]  mode_sel_q;

  // bus state
  logic                   rd_valid_q;
  logic [31:0]            rd_data_q;
  logic [31:0]            rd_data_d;
  logic [5:0]             word_idx;
  logic                   aligned;

  // timing state
  hce_pos_t               phase_q;
  logic                   blank_r1_q;
  logic                   blank_r2_q;
  logic [`HCE_WIDTH_W-1:0] wide_cnt_q;
  logic                   wide_q;
  logic [7:0]             h_q;
  logic [7:0]             h_d;
  logic                   last_q;
  logic                   rg_q;

  // decoded controls
  hce_mode_t              mode;
  logic [3:0]             retime;
  logic [3:0]             extra;
  logic [`HCE_WIDTH_W-1:0] wide_width;
  logic                   wide_en;
  logic                   last_blank_en;
  logic                   pixel_end;
  logic                   blk_first;
  logic                   blk_second;
  logic                   blk_last;
  logic                   blk_tri;
  logic [NGEN-1:0]        lvl;

  hce_edge_if eif [NGEN] ();

  function automatic logic [31:0] hce_merge(input logic [31:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // retime stages picked from raw gate, one stage or two stages
  function automatic logic hce_stage(input logic raw, input logic s1, input logic s2,
                                     input logic rt, input logic ex);
    logic r;
    case ({rt, ex})
      2'b00:   r = raw;
      2'b11:   r = s2;
      default: r = s1;
    endcase
    return r;
  endfunction

  // blanked clocks rest at their idle level or run wide
  function automatic logic hce_gate(input logic level, input logic blanked, input logic idle,
                                    input logic wen, input logic wide);
    logic r;
    if (!blanked) begin
      r = level;
    end else if (wen) begin
      r = wide ~^ idle;
    end else begin
      r = idle;
    end
    return r;
  endfunction

  assign word_idx = avs_address[7:2];
  assign aligned  = (avs_address[1:0] == 2'b00);

  // reads wait one cycle so read data comes from a flip-flop
  assign avs_waitrequest = avs_read & ~rd_valid_q;
  assign avs_readdata    = rd_data_q;

  // register writes, take effect at the edge where the write is seen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_q[G_FIRST]  <= `HCE_EDGE_RST;
      edge_q[G_SECOND] <= `HCE_EDGE_RST;
      edge_q[G_LAST]   <= `HCE_EDGE_RST;
      edge_q[G_P1]     <= `HCE_EDGE_RST;
      edge_q[G_RG]     <= `HCE_RG_EDGE_RST;
      blank_ctl_q      <= `HCE_BLK_RST;
      mode_sel_q       <= `HCE_SEL_RST;
    end else if (avs_write && aligned) begin
      case (word_idx)
        `HCE_IDX_FIRST: begin
          edge_q[G_FIRST] <= 17'(hce_merge({15'h0000, edge_q[G_FIRST]}, avs_writedata, avs_byteenable,
                                           32'h00013F3F));
        end
        `HCE_IDX_SECOND: begin
          edge_q[G_SECOND] <= 17'(hce_merge({15'h0000, edge_q[G_SECOND]}, avs_writedata, avs_byteenable,
                                            32'h00013F3F));
        end
        `HCE_IDX_LAST: begin
          edge_q[G_LAST] <= 17'(hce_merge({15'h0000, edge_q[G_LAST]}, avs_writedata, avs_byteenable,
                                          32'h00013F3F));
        end
        `HCE_IDX_PHASE_ONE: begin
          edge_q[G_P1] <= 17'(hce_merge({15'h0000, edge_q[G_P1]}, avs_writedata, avs_byteenable,
                                        32'h00013F3F));
        end
        `HCE_IDX_RESET_GATE: begin
          edge_q[G_RG] <= 17'(hce_merge({15'h0000, edge_q[G_RG]}, avs_writedata, avs_byteenable,
                                        32'h00013F3F));
        end
        `HCE_IDX_BLANK_CTL: begin
          blank_ctl_q <= 24'(hce_merge({8'h00, blank_ctl_q}, avs_writedata, avs_byteenable,
                                       32'h00FFFFFF));
        end
        `HCE_IDX_MODE_SEL: begin
          mode_sel_q <= 6'(hce_merge({26'h0000000, mode_sel_q}, avs_writedata, avs_byteenable,
                                     32'h0000003F));
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped or misaligned reads return zero
  always_comb begin
    rd_data_d = 32'h00000000;
    if (aligned) begin
      case (word_idx)
        `HCE_IDX_FIRST:      rd_data_d = {15'h0000, edge_q[G_FIRST]};
        `HCE_IDX_SECOND:     rd_data_d = {15'h0000, edge_q[G_SECOND]};
        `HCE_IDX_LAST:       rd_data_d = {15'h0000, edge_q[G_LAST]};
        `HCE_IDX_PHASE_ONE:  rd_data_d = {15'h0000, edge_q[G_P1]};
        `HCE_IDX_RESET_GATE: rd_data_d = {15'h0000, edge_q[G_RG]};
        `HCE_IDX_BLANK_CTL:  rd_data_d = {8'h00, blank_ctl_q};
        `HCE_IDX_MODE_SEL:   rd_data_d = {26'h0000000, mode_sel_q};
        `HCE_IDX_STATUS: begin
          rd_data_d = {7'h00, (mode == HCE_INVALID), 2'b00, phase_q, 6'h00, rg_q, last_q, h_q};
        end
        default:             rd_data_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 32'h00000000;
    end else begin
      rd_valid_q <= avs_read & ~rd_valid_q;
      if (avs_read && !rd_valid_q) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // decoded controls
  // one-hot selector
  assign mode          = hce_decode_mode(mode_sel_q[4:0]);
  assign retime        = blank_ctl_q[`HCE_RETIME_LSB +: 4];
  assign extra         = blank_ctl_q[`HCE_EXTRA_LSB +: 4];
  assign wide_width    = blank_ctl_q[`HCE_WIDTH_LSB +: `HCE_WIDTH_W];
  assign wide_en       = (wide_width != 4'h0);
  assign last_blank_en = blank_ctl_q[`HCE_LAST_BLANK_EN];
  assign pixel_end     = (phase_q == `HCE_LAST_POS);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 6'h00;
    end else begin
      phase_q <= phase_q + 6'h01;
    end
  end

  // edge generators, one per edge register
  for (genvar g = 0; g < NGEN; g++) begin : gen_edge
    assign eif[g].phase = phase_q;
    assign eif[g].rise  = edge_q[g][`HCE_RISE_LSB +: `HCE_POS_W];
    assign eif[g].fall  = edge_q[g][`HCE_FALL_LSB +: `HCE_POS_W];
    assign lvl[g]       = eif[g].level;
    hce_edge_gen u_gen (
      .clk    (clk),
      .resetn (resetn),
      .e      (eif[g])
    );
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blank_r1_q <= 1'b0;
      blank_r2_q <= 1'b0;
    end else begin
      blank_r1_q <= horizontal_blanking_gate;
      blank_r2_q <= blank_r1_q;
    end
  end

  assign blk_first  = hce_stage(horizontal_blanking_gate, blank_r1_q, blank_r2_q, retime[0], extra[0]);
  assign blk_second = hce_stage(horizontal_blanking_gate, blank_r1_q, blank_r2_q, retime[1], extra[1]);
  assign blk_last   = hce_stage(horizontal_blanking_gate, blank_r1_q, blank_r2_q, retime[2], extra[2]);
  assign blk_tri    = hce_stage(horizontal_blanking_gate, blank_r1_q, blank_r2_q, retime[3], extra[3]);

  // wide clock toggles every width pixels while blanking
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wide_cnt_q <= 4'h0;
      wide_q     <= 1'b1;
    end else if (!horizontal_blanking_gate || !wide_en) begin
      wide_cnt_q <= 4'h0;
      wide_q     <= 1'b1;
    end else if (pixel_end) begin
      if (wide_cnt_q == wide_width - 4'h1) begin
        wide_cnt_q <= 4'h0;
        wide_q     <= ~wide_q;
      end else begin
        wide_cnt_q <= wide_cnt_q + 4'h1;
      end
    end
  end

  // output routing per configuration
  always_comb begin
    logic a;
    logic b;
    logic c;
    a   = 1'b0;
    b   = 1'b0;
    c   = 1'b0;
    h_d = 8'h00;
    case (mode)
      HCE_MODE1: begin
        a   = hce_gate(lvl[G_FIRST], blk_first, 1'b1, wide_en, wide_q);
        h_d = {~a, a, ~a, a, ~a, a, ~a, a};
      end
      HCE_MODE2: begin
        a   = hce_gate(lvl[G_FIRST], blk_first, 1'b1, wide_en, wide_q);
        b   = hce_gate(lvl[G_SECOND], blk_second, 1'b0, wide_en, wide_q);
        h_d = {b, a, b, a, b, a, b, a};
      end
      HCE_MODE3: begin
        a   = hce_gate(lvl[G_FIRST], blk_first, 1'b1, wide_en, wide_q);
        c   = hce_gate(lvl[G_SECOND], blk_second, 1'b1, wide_en, wide_q);
        h_d = {~c, c, ~c, c, ~a, a, ~a, a};
      end
      HCE_TRIPHASE: begin
        // phase 1 on first and second
        a   = hce_gate(lvl[G_P1], blk_tri, 1'b1, wide_en, wide_q);
        // phase 2 on fifth and sixth
        b   = hce_gate(lvl[G_SECOND], blk_tri, 1'b1, wide_en, wide_q);
        // phase 3 on seventh and eighth
        c   = hce_gate(lvl[G_FIRST], blk_tri, 1'b1, wide_en, wide_q);
        h_d = {c, c, b, b, 2'b00, a, a};
      end
      default: begin
        // invalid selector parks all eight h_clk outputs low
        h_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_q    <= 8'h00;
      last_q <= 1'b0;
      rg_q   <= 1'b0;
    end else begin
      h_q    <= h_d;
      last_q <= last_blank_en ? hce_gate(lvl[G_LAST], blk_last, 1'b0, wide_en, wide_q) : lvl[G_LAST];
      rg_q   <= lvl[G_RG];
    end
  end

  assign h_clk                  = h_q;
  assign last_stage_horiz_clock = last_q;
  assign reset_gate_clock       = rg_q;

endmodule

// File: hce_map.svh
// register indices, field positions, reset values and timing counts of the edge timing core
`ifndef HCE_MAP_SVH
`define HCE_MAP_SVH

// register indices (byte address is four times the index)
`define HCE_IDX_MODE_SEL    6'h24
`define HCE_IDX_FIRST       6'h30
`define HCE_IDX_SECOND      6'h31
`define HCE_IDX_LAST        6'h32
`define HCE_IDX_PHASE_ONE   6'h33
`define HCE_IDX_RESET_GATE  6'h34
`define HCE_IDX_BLANK_CTL   6'h35
`define HCE_IDX_STATUS      6'h3F

// edge register fields
`define HCE_POS_W           6
`define HCE_RISE_LSB        0
`define HCE_FALL_LSB        8
`define HCE_EDGE_TEST_BIT   16
`define HCE_EDGE_W          17
`define HCE_EDGE_RST        17'h12000
`define HCE_RG_EDGE_RST     17'h11000

// blanking retime control fields
`define HCE_BLK_W           24
`define HCE_BLK_RST         24'h000000
`define HCE_RETIME_LSB      0
`define HCE_WIDTH_LSB       4
`define HCE_WIDTH_W         4
`define HCE_TEST_BIT8       8
`define HCE_LAST_BLANK_EN   9
`define HCE_EXTRA_LSB       20

// clock configuration selector
`define HCE_SEL_W           6
`define HCE_SEL_RST         6'h01
`define HCE_SEL_MODE1       5'h01
`define HCE_SEL_MODE2       5'h02
`define HCE_SEL_MODE3       5'h04
`define HCE_SEL_TRIPHASE    5'h10

// timing: edge positions per pixel period, one clk per position
`define HCE_POSITIONS       64
`define HCE_LAST_POS        6'h3F

`endif

// File: hce_pkg.sv
// types and decoding shared by the edge timing core
package hce_pkg;
  `include "hce_map.svh"

  typedef enum logic [2:0] {
    HCE_MODE1,
    HCE_MODE2,
    HCE_MODE3,
    HCE_TRIPHASE,
    HCE_INVALID
  } hce_mode_t;

  typedef logic [`HCE_POS_W-1:0] hce_pos_t;

  function automatic hce_mode_t hce_decode_mode(input logic [4:0] sel);
    hce_mode_t m;
    m = HCE_INVALID;
    case (sel)
      `HCE_SEL_MODE1:    m = HCE_MODE1;
      `HCE_SEL_MODE2:    m = HCE_MODE2;
      `HCE_SEL_MODE3:    m = HCE_MODE3;
      `HCE_SEL_TRIPHASE: m = HCE_TRIPHASE;
      default:           m = HCE_INVALID;
    endcase
    return m;
  endfunction
endpackage

// File: hce_edge_if.sv
// carrier between the core and one edge generator
`timescale 1ns/1ps
interface hce_edge_if;
  import hce_pkg::*;
  hce_pos_t phase;
  hce_pos_t rise;
  hce_pos_t fall;
  logic     level;

  modport ctl (output phase, output rise, output fall, input level);
  modport gen (input phase, input rise, input fall, output level);
endinterface

// File: hce_edge_gen.sv
// one programmable clock: sets at the rise position, clears at the fall position
`timescale 1ns/1ps
module hce_edge_gen
  import hce_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // edge configuration and level
  hce_edge_if.gen   e
);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      e.level <= 1'b0;
    end else if (e.phase == e.rise) begin
      e.level <= 1'b1;
    end else if (e.phase == e.fall) begin
      e.level <= 1'b0;
    end
  end

endmodule

// File: hce_timing_checker.sv
// port-level assertions of the edge timing core
`timescale 1ns/1ps
module hce_timing_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // blanking and clocks
  input wire logic        horizontal_blanking_gate,
  input wire logic [7:0]  h_clk,
  input wire logic        last_stage_horiz_clock
);
  logic [4:0]  sel_q;
  logic [23:0] blk_q;
  logic [2:0]  age_q;
  logic [2:0]  lo_q;
  logic [2:0]  hi_q;
  logic        calm;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow config; assumes full-word writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 5'h01;
      blk_q <= 24'h000000;
      age_q <= 3'h0;
    end else if (avs_write && (avs_address == 8'h90 || avs_address == 8'hD4)) begin
      if (avs_address == 8'h90) sel_q <= avs_writedata[4:0];
      else blk_q <= avs_writedata[23:0];
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // settle counters cover the retime and output flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_q <= 3'h0;
      hi_q <= 3'h0;
    end else begin
      lo_q <= horizontal_blanking_gate ? 3'h0 : (lo_q == 3'h7 ? lo_q : lo_q + 3'h1);
      hi_q <= !horizontal_blanking_gate ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
    end
  end
  assign calm = age_q >= 3'h5 && lo_q >= 3'h5;
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read did not take exactly one wait");
  a_rdata_holds: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_mode1_pairs: assert property (calm && sel_q == 5'h01 |-> h_clk == {4{~h_clk[0], h_clk[0]}})
    else $error("mode 1 outputs not complementary");
  a_mode2_pairs: assert property (calm && sel_q == 5'h02 |->
    {h_clk[6], h_clk[4], h_clk[2]} == {3{h_clk[0]}} && {h_clk[7], h_clk[5], h_clk[3]} == {3{h_clk[1]}})
    else $error("mode 2 outputs not grouped");
  a_mode3_pairs: assert property (calm && sel_q == 5'h04 |->
    h_clk[3:0] == {2{~h_clk[0], h_clk[0]}} && h_clk[7:4] == {2{~h_clk[4], h_clk[4]}})
    else $error("mode 3 outputs not grouped");
  a_tri_pairs: assert property (calm && sel_q == 5'h10 |-> h_clk[3:2] == 2'b00 &&
    h_clk[1] == h_clk[0] && h_clk[5] == h_clk[4] && h_clk[7] == h_clk[6])
    else $error("three-phase outputs not paired");
  a_invalid_quiet: assert property (age_q >= 3'h5 && !(sel_q inside {5'h01, 5'h02, 5'h04, 5'h10})
    |-> h_clk == 8'h00)
    else $error("invalid selector drives clocks");
  a_first_blanked: assert property (age_q >= 3'h5 && hi_q >= 3'h5 && sel_q == 5'h01 &&
    blk_q[7:4] == 4'h0 |-> h_clk[0])
    else $error("first clock not held during blanking");
  a_last_blanked: assert property (age_q >= 3'h5 && hi_q >= 3'h5 && blk_q[9] &&
    blk_q[7:4] == 4'h0 |-> !last_stage_horiz_clock)
    else $error("last-stage clock not held during blanking");
endmodule

// File: hce_ccd_drv_model.sv
// behavioural ccd clock drivers: log the time of every edge they receive
`timescale 1ns/1ps
module hce_ccd_drv_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // driven clock lines
  input wire logic [7:0] h_clk,
  input wire logic       last_stage_horiz_clock,
  input wire logic       reset_gate_clock
);
  int         cyc;
  int         rise_t [10];
  int         rise_p [10];
  int         fall_t [10];
  logic [9:0] prev;
  logic [9:0] now;
  assign now = {reset_gate_clock, last_stage_horiz_clock, h_clk};
  // drivers only load the lines; times are in pixel-clock positions
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc <= 0;
      prev <= '0;
    end else begin
      cyc <= cyc + 1;
      prev <= now;
      for (int i = 0; i < 10; i++) begin
        if (now[i] === 1'b1 && prev[i] === 1'b0) begin
          rise_p[i] <= rise_t[i];
          rise_t[i] <= cyc;
        end
        if (now[i] === 1'b0 && prev[i] === 1'b1) fall_t[i] <= cyc;
      end
    end
  end
endmodule

// File: tb_top.sv
// self-checking bench of the edge timing core
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        resetn;
  logic [7:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_r;
  logic        gate;
  logic [7:0]  h_clk;
  logic        hl;
  logic        rg;
  int          error_cnt;
  int          n_checks;
  hce_timing_core hce_timing_core_inst (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .horizontal_blanking_gate(gate), .h_clk(h_clk),
    .last_stage_horiz_clock(hl), .reset_gate_clock(rg));
  hce_ccd_drv_model hce_ccd_drv_model_inst (.clk(clk), .resetn(resetn), .h_clk(h_clk),
    .last_stage_horiz_clock(hl), .reset_gate_clock(rg));
  always #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    q = rdata;
    if (n == 50) check(32'h0, 32'h1);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic wr_edge(input logic [7:0] a, input logic [5:0] r, input logic [5:0] f);
    bus_wr(a, {15'h0, 1'b1, 2'b0, f, 2'b0, r});
  endtask
  function automatic logic [31:0] rdiff(input int a, input int b);
    return {26'h0, 6'(hce_ccd_drv_model_inst.rise_t[b] - hce_ccd_drv_model_inst.rise_t[a])};
  endfunction
  function automatic logic [31:0] wid(input int a);
    return {26'h0, 6'(hce_ccd_drv_model_inst.fall_t[a] - hce_ccd_drv_model_inst.rise_t[a])};
  endfunction
  task automatic wait_h0(input logic v);
    int n;
    n = 0;
    while (h_clk[0] !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs();
    logic [7:0]  a [7] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'h90};
    logic [31:0] r [7] = '{32'h12000, 32'h12000, 32'h12000, 32'h12000, 32'h11000, 32'h0, 32'h1};
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, a[i], 32'h0, d);
      check(d, r[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr_edge(a[i], 6'(i + 3), 6'(i + 40));
      bus(1'b0, a[i], 32'h0, d);
      check(d, {15'h0, 1'b1, 2'b0, 6'(i + 40), 2'b0, 6'(i + 3)});
    end
    bus_wr(8'hD4, 32'h00F002FF);
    bus(1'b0, 8'hD4, 32'h0, d);
    check(d, 32'h00F002FF);
    bus_wr(8'hD8, 32'hFFFF);
    bus(1'b0, 8'hD8, 32'h0, d);
    check(d, 32'h0);
    bus_wr(8'hC1, 32'h0);
    bus(1'b0, 8'hC0, 32'h0, d);
    check(d, 32'h12803);
    be <= 4'h2;
    bus_wr(8'hC0, 32'hFFFFFFFF);
    be <= 4'hF;
    bus(1'b0, 8'hC0, 32'h0, d);
    check(d, 32'h13F03);
    bus_wr(8'hD4, 32'h0);
  endtask
  task automatic t_edges();
    wr_edge(8'hC0, 6'h05, 6'h25);
    wr_edge(8'hC8, 6'h0A, 6'h14);
    wr_edge(8'hD0, 6'h3E, 6'h03);
    idle(200);
    check(wid(0), 32'd32);
    check(rdiff(0, 1), 32'd32);
    check(rdiff(0, 8), 32'd5);
    check(wid(8), 32'd10);
    check(wid(9), 32'd5);
    check(32'(hce_ccd_drv_model_inst.rise_t[9] - hce_ccd_drv_model_inst.rise_p[9]), 32'd64);
  endtask
  task automatic t_modes();
    logic [31:0] d;
    wr_edge(8'hC0, 6'h00, 6'h20);
    wr_edge(8'hC4, 6'h08, 6'h10);
    wr_edge(8'hCC, 6'h28, 6'h30);
    bus_wr(8'h90, 32'h02);
    idle(200);
    check(rdiff(0, 1), 32'd8);
    check(wid(1), 32'd8);
    bus_wr(8'h90, 32'h04);
    idle(200);
    check(rdiff(0, 4), 32'd8);
    check(wid(4), 32'd8);
    bus_wr(8'h90, 32'h10);
    idle(200);
    check(rdiff(6, 0), 32'd40);
    check(wid(0), 32'd8);
    check(rdiff(6, 4), 32'd8);
    check(wid(6), 32'd32);
    bus_wr(8'h90, 32'h08);
    idle(100);
    check({24'h0, h_clk}, 32'h0);
    bus(1'b0, 8'hFC, 32'h0, d);
    check(d & 32'h010000FF, 32'h01000000);
    bus_wr(8'h90, 32'h01);
    idle(100);
  endtask
  task automatic t_retime();
    int lat [4];
    int n;
    for (int i = 0; i < 4; i++) begin
      bus_wr(8'hD4, {11'h0, i[1], 19'h0, i[0]});
      wait_h0(1'b1);
      wait_h0(1'b0);
      idle(4);
      n = 0;
      gate <= 1'b1;
      do begin
        @(posedge clk);
        n++;
      end while (h_clk[0] !== 1'b1 && n < 40);
      lat[i] = n;
      gate <= 1'b0;
      idle(70);
      check(32'(lat[i] - lat[0]), 32'(i % 2 + i / 2));
    end
    check(32'(lat[0]), 32'd2);
  endtask
  task automatic blank_win(input logic [31:0] ctl, output int hl_hi, output int h0_lo);
    hl_hi = 0;
    h0_lo = 0;
    bus_wr(8'hD4, ctl);
    gate <= 1'b1;
    idle(8);
    repeat (200) begin
      @(posedge clk);
      if (hl === 1'b1) hl_hi++;
      if (h_clk[0] === 1'b0) h0_lo++;
    end
    gate <= 1'b0;
    idle(70);
  endtask
  task automatic t_window();
    int a;
    int b;
    blank_win(32'h200, a, b);
    check(32'(a), 32'h0);
    check(32'(b), 32'h0);
    blank_win(32'h0, a, b);
    check(32'(a > 0), 32'h1);
    blank_win(32'h210, a, b);
    check(32'(b > 0), 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {adr, rd, wr, wd, gate} = '0;
    be = 4'hF;
    error_cnt = 0;
    n_checks = 0;
    idle(3);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edges();
    t_modes();
    t_retime();
    t_window();
    results();
  end
  initial begin
    idle(20000);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
endmodule
bind hce_timing_core hce_timing_checker hce_timing_checker_inst (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .horizontal_blanking_gate(horizontal_blanking_gate), .h_clk(h_clk),
  .last_stage_horiz_clock(last_stage_horiz_clock));
